//--- hdl/i2sap_pkg.sv
// Constants shared by the serial audio port: offsets, fields, resets.
// Assumes a 32-bit AHB-Lite bus with one 8-bit register per word.
package i2sap_pkg;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] CFG0_OFS = 8'h00;
  localparam logic [7:0] CFG1_OFS = 8'h04;
  localparam logic [7:0] FLAG_OFS = 8'h08;
  localparam logic [7:0] LOW_OFS = 8'h0C;
  localparam logic [7:0] HIGH_OFS = 8'h10;
  localparam logic [7:0] DIV0_OFS = 8'h14;
  localparam logic [7:0] DIV1_OFS = 8'h18;
  localparam logic [7:0] DIV2_OFS = 8'h1C;
  localparam logic [7:0] SYS_OFS = 8'h20;
  // ==========================================
  // Field positions of config_reg0
  localparam int C0_TXMSK = 7;
  localparam int C0_RXMSK = 6;
  localparam int C0_EXP = 5;
  localparam int C0_CMP = 4;
  localparam int C0_TX_SINGLE_CHANNEL = 3;
  localparam int C0_RX_SINGLE_CHANNEL = 2;
  localparam int C0_MASTER = 1;
  localparam int C0_ON = 0;
  // Field positions of port_flag_reg
  localparam int FL_RXC = 0;
  localparam int FL_TXC = 1;
  localparam int FL_UNF = 2;
  localparam int FL_OVF = 3;
  localparam int FL_TX_CHANNEL_FLAG = 4;
  localparam int FL_RX_CHANNEL_FLAG = 5;
  // Field positions of the system flag register
  localparam int SY_TXF = 0;
  localparam int SY_RXF = 1;
  localparam int SY_TXIE = 2;
  localparam int SY_RXIE = 3;
  // ==========================================
  // Reset values and sizes
  localparam logic [7:0] CFG0_RST = 8'h00;
  localparam logic [4:0] WSIZE_RST = 5'h0F;
  localparam logic [7:0] DIV0_RST = 8'h01;
  localparam logic [7:0] DIV1_RST = 8'h08;
  localparam logic [7:0] DIV2_RST = 8'h00;
  localparam int SAMPLE_W = 16;
  localparam int RX_DMA_NUM = 27;
  localparam int TX_DMA_NUM = 28;
endpackage

//--- hdl/i2sap_port.sv
// Serial audio port with AHB-Lite registers, master or slave clocking.
// Assumes pins arrive unsynchronised; the bus is a single-slave AHB-Lite.
// Summary of operation
// - One bit per clock period, MSB first.
// - Word select low left, high right.
// - Word select flips one bit early.
// - Master drives clock, select; slave receives.
// - Serial path runs only while enabled.
// - Transmit fetch sets complete and system flags.
// - Receive copy sets complete and system flags.
// - Request needs local mask and system enable.
// - Software-set complete flags also raise requests.
// - Unmasked DMA pulse on each complete event.
// - Empty transmit buffer resends, flags underflow.
// - Full receive buffer overwritten, flags overflow.
// - Underflow, overflow cleared only by software.
// - High byte write completes a sample.
// - High byte read completes a read.
// - Channel flags name next and held sample.
// - Mono uses one sample for both.
// - Master bit selects master or slave.
// - Clock is system over twice ratio.
// - Numerator, denominator split over divider registers.
// - Serial path disabled after reset.
// - Master word length programmed minus one.
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module i2sap_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Audio pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic ws_i,
  output logic ws_o,
  output logic ws_oe,
  input wire logic sd_rx,
  output logic sd_tx,
  // Requests and triggers
  output logic tx_irq,
  output logic rx_irq,
  output logic tx_dma_trigger,
  output logic rx_dma_trigger
);
  // ==========================================
  // Bus slave
  logic [7:0] cfg0_reg, div0_reg, div1_reg, div2_reg;
  logic [4:0] wsize_reg;
  logic rxc_reg, txc_reg, unf_reg, ovf_reg, tx_channel_flag_reg, rx_channel_flag_reg;
  logic systx_reg, sysrx_reg, txie_reg, rxie_reg;
  logic [15:0] tx_data_reg, rx_data_reg, tx_buf_reg;
  logic tx_fresh_reg, rx_full_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic hready_reg, hresp_reg;
  logic accept, rd_high_ev;
  logic [7:0] wd, rd_val;

  // An access is taken on a selected, word-sized, active transfer.
  assign accept = hsel && hready && htrans[1] && hsize == 3'h2;
  assign wd = hwdata[7:0];
  assign rd_high_ev = accept && !hwrite && haddr == {24'h000000, i2sap_pkg::HIGH_OFS};

  // True when the pending write targets the given offset.
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_pend_reg && wr_addr_reg == ofs;
  endfunction

  // The write is carried out in its data phase.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= accept && hwrite && haddr[31:8] == 24'h000000;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Read data is selected in the address phase; unmapped reads give zero.
  always_comb begin
    rd_val = 8'h00;
    if (haddr[31:8] != 24'h000000) begin
      rd_val = 8'h00;
    end else if (haddr[7:0] == i2sap_pkg::CFG0_OFS) begin
      rd_val = cfg0_reg;
    end else if (haddr[7:0] == i2sap_pkg::CFG1_OFS) begin
      rd_val = {3'h0, wsize_reg};
    end else if (haddr[7:0] == i2sap_pkg::FLAG_OFS) begin
      rd_val = {2'h0, rx_channel_flag_reg, tx_channel_flag_reg, ovf_reg, unf_reg, txc_reg, rxc_reg};
    end else if (haddr[7:0] == i2sap_pkg::LOW_OFS) begin
      rd_val = rx_data_reg[7:0];
    end else if (haddr[7:0] == i2sap_pkg::HIGH_OFS) begin
      rd_val = rx_data_reg[15:8];
    end else if (haddr[7:0] == i2sap_pkg::DIV0_OFS) begin
      rd_val = div0_reg;
    end else if (haddr[7:0] == i2sap_pkg::DIV1_OFS) begin
      rd_val = div1_reg;
    end else if (haddr[7:0] == i2sap_pkg::DIV2_OFS) begin
      rd_val = div2_reg;
    end else if (haddr[7:0] == i2sap_pkg::SYS_OFS) begin
      rd_val = {4'h0, rxie_reg, txie_reg, sysrx_reg, systx_reg};
    end
  end

  // Zero-wait answer, always OKAY.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hrdata_reg <= 32'h00000000;
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
      if (accept && !hwrite) begin
        hrdata_reg <= {24'h000000, rd_val};
      end
    end
  end
  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = hresp_reg;

  // Configuration and divider registers.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg0_reg <= i2sap_pkg::CFG0_RST;
      wsize_reg <= i2sap_pkg::WSIZE_RST;
      div0_reg <= i2sap_pkg::DIV0_RST;
      div1_reg <= i2sap_pkg::DIV1_RST;
      div2_reg <= i2sap_pkg::DIV2_RST;
      txie_reg <= 1'b0;
      rxie_reg <= 1'b0;
    end else begin
      if (wr_hit(i2sap_pkg::CFG0_OFS)) cfg0_reg <= wd;
      if (wr_hit(i2sap_pkg::CFG1_OFS)) wsize_reg <= wd[4:0];
      if (wr_hit(i2sap_pkg::DIV0_OFS)) div0_reg <= wd;
      if (wr_hit(i2sap_pkg::DIV1_OFS)) div1_reg <= wd;
      if (wr_hit(i2sap_pkg::DIV2_OFS)) div2_reg <= wd;
      if (wr_hit(i2sap_pkg::SYS_OFS)) begin
        txie_reg <= wd[i2sap_pkg::SY_TXIE];
        rxie_reg <= wd[i2sap_pkg::SY_RXIE];
      end
    end
  end

  // ==========================================
  // Clocking: pin synchronisers and fractional divider
  logic sck_s1, sck_s2, sck_s3, ws_s1, ws_s2, sd_s1, sd_s2;
  logic on, master, tick, rise, fall;
  logic [15:0] acc_reg;
  logic [16:0] acc_sum;
  logic [14:0] num;
  logic [8:0] den;
  logic sck_reg, ws_reg, sck_oe_reg, ws_oe_reg;
  logic [4:0] bit_cnt_reg;

  assign on = cfg0_reg[i2sap_pkg::C0_ON];
  assign master = cfg0_reg[i2sap_pkg::C0_MASTER];

  // Two flops on every pin before use; a third stage finds clock edges.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {ws_s1, ws_s2, sd_s1, sd_s2} <= 4'h0;
    end else begin
      {sck_s1, ws_s1, sd_s1} <= {sck_i, ws_i, sd_rx};
      {sck_s2, ws_s2, sd_s2} <= {sck_s1, ws_s1, sd_s1};
      sck_s3 <= sck_s2;
    end
  end

  assign num = {div2_reg[6:0], div1_reg};
  assign den = {div2_reg[7], div0_reg};
  assign acc_sum = {1'b0, acc_reg} + {8'h00, den};
  assign tick = on && master && acc_sum >= {2'h0, num};

  // Accumulator adds the denominator and removes the numerator on a tick.
  always_ff @(posedge core_clk) begin
    if (reset || !on || !master) begin
      acc_reg <= 16'h0000;
    end else if (tick) begin
      acc_reg <= acc_sum[15:0] - {1'b0, num};
    end else begin
      acc_reg <= acc_sum[15:0];
    end
  end

  assign rise = on && (master ? (tick && !sck_reg) : (sck_s2 && !sck_s3));
  assign fall = on && (master ? (tick && sck_reg) : (!sck_s2 && sck_s3));

  // Master clock and word select; select starts high so it flips to left first.
  always_ff @(posedge core_clk) begin
    if (reset || !on || !master) begin
      sck_reg <= 1'b0;
      ws_reg <= 1'b1;
      bit_cnt_reg <= wsize_reg;
    end else if (tick) begin
      sck_reg <= !sck_reg;
      if (sck_reg) begin
        if (bit_cnt_reg == wsize_reg) begin
          bit_cnt_reg <= 5'h00;
          ws_reg <= !ws_reg;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sck_oe_reg <= 1'b0;
      ws_oe_reg <= 1'b0;
    end else begin
      sck_oe_reg <= master;
      ws_oe_reg <= master;
    end
  end
  assign sck_o = sck_reg;
  assign ws_o = ws_reg;
  assign sck_oe = sck_oe_reg;
  assign ws_oe = ws_oe_reg;

  // ==========================================
  // Framing and receive path
  logic ws_smp, ws_last_reg, sync_reg, new_word_reg, boundary;
  logic [15:0] rx_sh_reg, rx_in, rx_word;
  logic [4:0] rx_cnt_reg;
  logic rx_done_ev, rx_ovf_ev;

  assign ws_smp = master ? ws_reg : ws_s2;
  assign boundary = rise && ws_smp != ws_last_reg;

  // Select history and word-start marker for the transmitter.
  always_ff @(posedge core_clk) begin
    if (reset || !on) begin
      ws_last_reg <= 1'b1;
      sync_reg <= 1'b0;
      new_word_reg <= 1'b0;
    end else begin
      if (rise) ws_last_reg <= ws_smp;
      if (boundary) sync_reg <= 1'b1;
      if (boundary) begin
        new_word_reg <= 1'b1;
      end else if (fall) begin
        new_word_reg <= 1'b0;
      end
    end
  end

  assign rx_in = {rx_sh_reg[14:0], sd_s2};
  assign rx_word = rx_cnt_reg[4] ? rx_sh_reg : rx_in << (4'hF - rx_cnt_reg[3:0]);
  assign rx_done_ev = boundary && sync_reg &&
                      !(cfg0_reg[i2sap_pkg::C0_RX_SINGLE_CHANNEL] && ws_last_reg);
  assign rx_ovf_ev = rx_done_ev && rx_full_reg;

  // Receive shifter samples on the rising clock edge.
  always_ff @(posedge core_clk) begin
    if (reset || !on) begin
      rx_sh_reg <= 16'h0000;
      rx_cnt_reg <= 5'h00;
    end else if (boundary) begin
      rx_sh_reg <= 16'h0000;
      rx_cnt_reg <= 5'h00;
    end else if (rise && !rx_cnt_reg[4]) begin
      rx_sh_reg <= rx_in;
      rx_cnt_reg <= rx_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_data_reg <= 16'h0000;
      rx_full_reg <= 1'b0;
      rx_channel_flag_reg <= 1'b0;
    end else if (rx_done_ev) begin
      rx_data_reg <= rx_word;
      rx_full_reg <= 1'b1;
      rx_channel_flag_reg <= ws_last_reg;
    end else if (rd_high_ev) begin
      rx_full_reg <= 1'b0;
    end
  end

  // ==========================================
  // Transmit path
  logic tx_fetch_ev, tx_unf_ev, tx_load;
  logic [15:0] tx_sh_reg, tx_val;
  logic sd_reg;

  assign tx_load = fall && new_word_reg && sync_reg;
  assign tx_fetch_ev = tx_load && !(cfg0_reg[i2sap_pkg::C0_TX_SINGLE_CHANNEL] && ws_last_reg);
  assign tx_unf_ev = tx_fetch_ev && !tx_fresh_reg;
  assign tx_val = (tx_fetch_ev && tx_fresh_reg) ? tx_data_reg : tx_buf_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_data_reg <= 16'h0000;
      tx_fresh_reg <= 1'b0;
    end else begin
      if (wr_hit(i2sap_pkg::LOW_OFS)) tx_data_reg[7:0] <= wd;
      if (wr_hit(i2sap_pkg::HIGH_OFS)) begin
        tx_data_reg[15:8] <= wd;
        tx_fresh_reg <= 1'b1;
      end else if (tx_fetch_ev) begin
        tx_fresh_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || !on) begin
      tx_sh_reg <= 16'h0000;
      sd_reg <= 1'b0;
    end else if (tx_load) begin
      sd_reg <= tx_val[15];
      tx_sh_reg <= {tx_val[14:0], 1'b0};
    end else if (fall) begin
      sd_reg <= tx_sh_reg[15];
      tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
    end
  end
  assign sd_tx = sd_reg;

  // Internal buffer keeps the last fetched sample for repeats.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_buf_reg <= 16'h0000;
      tx_channel_flag_reg <= 1'b0;
    end else if (tx_load) begin
      tx_buf_reg <= tx_val;
      tx_channel_flag_reg <= !ws_last_reg;
    end
  end

  // ==========================================
  // Flags, requests and triggers
  // set wins over high write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txc_reg <= 1'b0;
      rxc_reg <= 1'b0;
    end else begin
      if (tx_fetch_ev) begin
        txc_reg <= 1'b1;
      end else if (wr_hit(i2sap_pkg::HIGH_OFS)) begin
        txc_reg <= 1'b0;
      end else if (wr_hit(i2sap_pkg::FLAG_OFS)) begin
        txc_reg <= wd[i2sap_pkg::FL_TXC];
      end
      if (rx_done_ev) begin
        rxc_reg <= 1'b1;
      end else if (rd_high_ev) begin
        rxc_reg <= 1'b0;
      end else if (wr_hit(i2sap_pkg::FLAG_OFS)) begin
        rxc_reg <= wd[i2sap_pkg::FL_RXC];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      unf_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      if (tx_unf_ev) begin
        unf_reg <= 1'b1;
      end else if (wr_hit(i2sap_pkg::FLAG_OFS)) begin
        unf_reg <= wd[i2sap_pkg::FL_UNF];
      end
      if (rx_ovf_ev) begin
        ovf_reg <= 1'b1;
      end else if (wr_hit(i2sap_pkg::FLAG_OFS)) begin
        ovf_reg <= wd[i2sap_pkg::FL_OVF];
      end
    end
  end

  // System flags set with the complete flags; software writes them.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      systx_reg <= 1'b0;
      sysrx_reg <= 1'b0;
    end else begin
      if (tx_fetch_ev) begin
        systx_reg <= 1'b1;
      end else if (wr_hit(i2sap_pkg::SYS_OFS)) begin
        systx_reg <= wd[i2sap_pkg::SY_TXF];
      end
      if (rx_done_ev) begin
        sysrx_reg <= 1'b1;
      end else if (wr_hit(i2sap_pkg::SYS_OFS)) begin
        sysrx_reg <= wd[i2sap_pkg::SY_RXF];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      tx_dma_trigger <= 1'b0;
      rx_dma_trigger <= 1'b0;
    end else begin
      tx_irq <= txc_reg && cfg0_reg[i2sap_pkg::C0_TXMSK] && txie_reg;
      rx_irq <= rxc_reg && cfg0_reg[i2sap_pkg::C0_RXMSK] && rxie_reg;
      tx_dma_trigger <= tx_fetch_ev;
      rx_dma_trigger <= rx_done_ev;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  ws_flip_a: assert property (tick && sck_reg && bit_cnt_reg == wsize_reg
    |=> ws_reg != $past(ws_reg)) else $error("select did not flip");
  off_quiet_a: assert property (!on |=> !sck_reg && !sd_reg)
    else $error("serial path active while off");
  tx_done_a: assert property (tx_fetch_ev |=> txc_reg && systx_reg
    && tx_dma_trigger) else $error("transmit fetch not flagged");
  rx_done_a: assert property (rx_done_ev |=> rxc_reg && sysrx_reg
    && rx_data_reg == $past(rx_word)) else $error("receive copy wrong");
  irq_gate_a: assert property (tx_irq |-> $past(txc_reg)
    && $past(txie_reg) && $past(cfg0_reg[i2sap_pkg::C0_TXMSK])) else $error("ungated request");
  dma_free_a: assert property (rx_done_ev |=> rx_dma_trigger)
    else $error("trigger masked");
  unf_stale_a: assert property (tx_unf_ev |=> unf_reg
    && tx_buf_reg == $past(tx_buf_reg)) else $error("underflow handling");
  ovf_set_a: assert property (rx_ovf_ev |=> ovf_reg)
    else $error("overflow not flagged");
  err_hold_a: assert property (ovf_reg && !wr_hit(i2sap_pkg::FLAG_OFS)
    |=> ovf_reg) else $error("overflow cleared by hardware");
  msb_first_a: assert property (tx_load && tx_fresh_reg && tx_fetch_ev
    |=> sd_reg == $past(tx_data_reg[15])) else $error("MSB not first");

  fetch_c: cover property (tx_fetch_ev ##[1:600] tx_fetch_ev);
  rxdone_c: cover property (rx_done_ev);
  ovf_c: cover property (rx_ovf_ev);
  unf_c: cover property (tx_unf_ev);
endmodule

//--- tb/i2s_audio_port_tb.sv
// Self-checking bench for the serial audio port over AHB-Lite.
// Assumes one slave on the bus and the codec model as the far side.
`timescale 1ns/1ps
module i2s_audio_port_tb;
  // ==========================================
  // Signals
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sck_o, sck_oe, ws_o, ws_oe, sd_rx, sd_tx;
  logic tx_irq, rx_irq, tx_dma_trigger, rx_dma_trigger, sck_pin, ws_pin;
  logic [15:0] cap_l, cap_r;
  logic ext_sck = 1'h0;
  logic ext_ws = 1'h0;
  logic [3:0] ext_div = 4'h0;
  logic [3:0] ext_bit = 4'h0;
  logic [31:0] rd, chv;
  int cap_len, t0, txb, err_count = 0, n_tests = 0, cyc = 0, tx_cnt = 0, rx_cnt = 0;
  logic [7:0] ra [8] = '{i2sap_pkg::CFG0_OFS, i2sap_pkg::CFG1_OFS, i2sap_pkg::FLAG_OFS,
    i2sap_pkg::DIV0_OFS, i2sap_pkg::DIV1_OFS, i2sap_pkg::DIV2_OFS, i2sap_pkg::SYS_OFS, 8'h40};
  logic [31:0] rv [8] = '{32'h00, 32'h0F, 32'h00, 32'h01, 32'h08, 32'h00, 32'h00, 32'h00};
  logic [31:0] im_cfg [4] = '{32'hC0, 32'h40, 32'hC0, 32'h00};
  logic [31:0] im_sys [4] = '{32'h0C, 32'h0C, 32'h04, 32'h0C};
  logic [31:0] im_exp [4] = '{32'h3, 32'h2, 32'h1, 32'h0};
  logic [15:0] rx_pat [2] = '{16'h9C31, 16'h5AE7};

  // Clock of 20 ns period.
  always #10 core_clk = ~core_clk;

  // Pins follow the bench's external master whenever the port does not drive them.
  assign sck_pin = (sck_oe === 1'h1) ? sck_o : ext_sck;
  assign ws_pin = (ws_oe === 1'h1) ? ws_o : ext_ws;

  // External master: free-running bit clock of 16 core cycles, 16-bit words.
  always @(posedge core_clk) begin
    ext_div <= ext_div + 4'h1;
    if (ext_div == 4'h7) ext_sck <= 1'h1;
    if (ext_div == 4'hF) begin
      ext_sck <= 1'h0;
      ext_bit <= ext_bit + 4'h1;
      if (ext_bit == 4'hF) ext_ws <= ~ext_ws;
    end
  end

  // ==========================================
  // Device and far side
  i2sap_port uut (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe(sck_oe),
    .ws_i(ws_pin), .ws_o(ws_o), .ws_oe(ws_oe), .sd_rx(sd_rx), .sd_tx(sd_tx),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .tx_dma_trigger(tx_dma_trigger),
    .rx_dma_trigger(rx_dma_trigger)
  );
  i2sap_codec #(.LEFT_PAT(16'h9C31), .RIGHT_PAT(16'h5AE7)) codec (
    .sck(sck_pin), .ws(ws_pin), .sd_in(sd_tx), .sd_out(sd_rx),
    .left_word(cap_l), .right_word(cap_r), .word_len(cap_len)
  );

  // Counts cycles and trigger pulses, and cuts a hang short.
  always @(posedge core_clk) begin
    cyc++;
    if (tx_dma_trigger === 1'h1) tx_cnt++;
    if (rx_dma_trigger === 1'h1) rx_cnt++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // ==========================================
  // Tasks
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches.", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One single-word AHB-Lite transfer; read data lands in rd.
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= 3'h2;
    do begin
      @(posedge core_clk);
    end while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    do begin
      @(posedge core_clk);
    end while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  // Waits until a trigger count reaches the target; the cycle ceiling ends a hang.
  task automatic wait_dma(input logic tx, input int target);
    while ((tx ? tx_cnt : rx_cnt) < target) begin
      @(posedge core_clk);
    end
  endtask

  function automatic logic [31:0] fld(input int pos);
    return (rd >> pos) & 32'h00000001;
  endfunction

  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      ahb_xfer(1'h0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    chk({29'h0, hresp, ws_oe, sck_oe}, 32'h0);
    $display("Test reset values done.");

    // Software-set flags against four mask and enable combinations.
    for (int i = 0; i < 4; i++) begin
      ahb_xfer(1'h1, i2sap_pkg::CFG0_OFS, im_cfg[i]);
      ahb_xfer(1'h1, i2sap_pkg::SYS_OFS, im_sys[i]);
      ahb_xfer(1'h1, i2sap_pkg::FLAG_OFS, 32'h3);
      repeat (3) @(posedge core_clk);
      chk({30'h0, rx_irq, tx_irq}, im_exp[i]);
    end
    ahb_xfer(1'h1, i2sap_pkg::FLAG_OFS, 32'h0);
    ahb_xfer(1'h1, i2sap_pkg::SYS_OFS, 32'h0);
    ahb_xfer(1'h1, i2sap_pkg::CFG0_OFS, 32'h0);
    $display("Test request masking done.");

    // Ratio 2048/256 = 8 through both split fields, set before master mode.
    ahb_xfer(1'h1, i2sap_pkg::DIV0_OFS, 32'h00);
    ahb_xfer(1'h1, i2sap_pkg::DIV1_OFS, 32'h00);
    ahb_xfer(1'h1, i2sap_pkg::DIV2_OFS, 32'h88);
    ahb_xfer(1'h1, i2sap_pkg::LOW_OFS, 32'hA5);
    ahb_xfer(1'h1, i2sap_pkg::HIGH_OFS, 32'hC3);
    txb = tx_cnt;
    ahb_xfer(1'h1, i2sap_pkg::CFG0_OFS, 32'hCB);
    repeat (3) @(posedge core_clk);
    chk({30'h0, ws_oe, sck_oe}, 32'h3);
    @(posedge sck_o);
    t0 = cyc;
    @(posedge sck_o);
    chk(32'(cyc - t0), 32'h10);
    @(posedge core_clk);
    $display("Test master clocking done.");

    // First fetch, then one received word read low then high.
    wait_dma(1'h1, txb + 1);
    ahb_xfer(1'h0, i2sap_pkg::FLAG_OFS, 32'h0);
    chk(fld(i2sap_pkg::FL_TXC), 32'h1);
    ahb_xfer(1'h0, i2sap_pkg::SYS_OFS, 32'h0);
    chk(fld(i2sap_pkg::SY_TXF), 32'h1);
    chk({31'h0, tx_irq}, 32'h0);
    wait_dma(1'h0, rx_cnt + 1);
    ahb_xfer(1'h0, i2sap_pkg::FLAG_OFS, 32'h0);
    chv = fld(i2sap_pkg::FL_RX_CHANNEL_FLAG);
    ahb_xfer(1'h0, i2sap_pkg::LOW_OFS, 32'h0);
    chk(rd, {24'h0, rx_pat[chv[0]][7:0]});
    ahb_xfer(1'h0, i2sap_pkg::HIGH_OFS, 32'h0);
    chk(rd, {24'h0, rx_pat[chv[0]][15:8]});
    ahb_xfer(1'h0, i2sap_pkg::FLAG_OFS, 32'h0);
    chk(fld(i2sap_pkg::FL_RXC), 32'h0);
    ahb_xfer(1'h0, i2sap_pkg::SYS_OFS, 32'h0);
    chk(fld(i2sap_pkg::SY_RXF), 32'h1);
    $display("Test receive path done.");

    // Second fetch with nothing new written, then a fresh sample.
    wait_dma(1'h1, txb + 2);
    ahb_xfer(1'h0, i2sap_pkg::FLAG_OFS, 32'h0);
    chk(fld(i2sap_pkg::FL_UNF), 32'h1);
    ahb_xfer(1'h1, i2sap_pkg::LOW_OFS, 32'h3C);
    ahb_xfer(1'h1, i2sap_pkg::HIGH_OFS, 32'h5A);
    ahb_xfer(1'h0, i2sap_pkg::FLAG_OFS, 32'h0);
    chk(fld(i2sap_pkg::FL_TXC), 32'h0);
    wait_dma(1'h1, txb + 4);
    repeat (2) @(posedge core_clk);
    chk({16'h0, cap_l}, 32'h5A3C);
    chk({16'h0, cap_r}, 32'h5A3C);
    chk(32'(cap_len), 32'h10);
    ahb_xfer(1'h0, i2sap_pkg::FLAG_OFS, 32'h0);
    chk(fld(i2sap_pkg::FL_OVF), 32'h1);
    $display("Test transmit path done.");

    // Slave with mono receive: only left words reach the data registers.
    ahb_xfer(1'h1, i2sap_pkg::CFG0_OFS, 32'h00);
    ahb_xfer(1'h1, i2sap_pkg::CFG0_OFS, 32'hC5);
    repeat (3) @(posedge core_clk);
    chk({30'h0, ws_oe, sck_oe}, 32'h0);
    wait_dma(1'h0, rx_cnt + 2);
    ahb_xfer(1'h0, i2sap_pkg::FLAG_OFS, 32'h0);
    chk(fld(i2sap_pkg::FL_RX_CHANNEL_FLAG), 32'h0);
    chk(fld(i2sap_pkg::FL_TX_CHANNEL_FLAG), 32'h1);
    ahb_xfer(1'h0, i2sap_pkg::LOW_OFS, 32'h0);
    chk(rd, {24'h0, rx_pat[0][7:0]});
    ahb_xfer(1'h0, i2sap_pkg::HIGH_OFS, 32'h0);
    chk(rd, {24'h0, rx_pat[0][15:8]});
    $display("Test slave receive done.");

    // Switch off; serial activity stops, sticky flags stay until cleared.
    ahb_xfer(1'h1, i2sap_pkg::CFG0_OFS, 32'h0);
    repeat (4) @(posedge core_clk);
    t0 = tx_cnt + rx_cnt;
    repeat (600) @(posedge core_clk);
    chk(32'(tx_cnt + rx_cnt - t0), 32'h0);
    chk({31'h0, sck_o}, 32'h0);
    ahb_xfer(1'h0, i2sap_pkg::FLAG_OFS, 32'h0);
    chk(rd & 32'h0C, 32'h0C);
    ahb_xfer(1'h1, i2sap_pkg::FLAG_OFS, 32'h0);
    ahb_xfer(1'h0, i2sap_pkg::FLAG_OFS, 32'h0);
    chk(rd & 32'h0F, 32'h0);
    $display("Test disable and flags done.");
    give_verdict();
  end
endmodule

//--- tb/i2sap_codec.sv
// Behavioural model of an external slave audio codec on the serial port.
// Assumes the port or the bench's external master drives clock and word select.
`timescale 1ns/1ps
module i2sap_codec #(
  parameter logic [15:0] LEFT_PAT = 16'h9C31,
  parameter logic [15:0] RIGHT_PAT = 16'h5AE7
) (
  // Serial pins
  input wire logic sck,
  input wire logic ws,
  input wire logic sd_in,
  output logic sd_out,
  // Last words captured
  output logic [15:0] left_word,
  output logic [15:0] right_word,
  output int word_len
);
  // ==========================================
  // Capture and playback state
  logic [15:0] shreg;
  logic ws_prev;
  logic ch;
  int bits;
  int idx;

  // Start quiet, with a known channel before the first clock.
  initial begin
    sd_out = 1'h0;
    left_word = 16'h0000;
    right_word = 16'h0000;
    word_len = 0;
    shreg = 16'h0000;
    ws_prev = 1'h0;
    ch = 1'h0;
    bits = 0;
    idx = 15;
  end

  // sample on rise, close word on select change.
  always @(posedge sck) begin
    shreg = {shreg[14:0], sd_in};
    bits = bits + 1;
    if (ws !== ws_prev) begin
      if (ws_prev === 1'h1) right_word = shreg;
      else left_word = shreg;
      word_len = bits;
      bits = 0;
      idx = 15;
      ch = ws;
      ws_prev = ws;
    end
  end

  // drive data after fall, MSB first, as a slave.
  always @(negedge sck) begin
    #2 sd_out = ch ? RIGHT_PAT[idx[3:0]] : LEFT_PAT[idx[3:0]];
    idx = (idx == 0) ? 15 : idx - 1;
  end
endmodule
